// File: verilog/qasr_sar.sv
// Shared constants and the per-channel successive approximation engine
package qasr_pkg;
  localparam int QASR_CODE_BITS = 13;
  localparam int QASR_CHANNELS = 4;
  localparam int QASR_SDR_EDGES = 16;
  localparam int QASR_DDR_EDGES = 8;
  localparam int QASR_IDX_BITS = 5;
  localparam logic [12:0] QASR_SIGN_FLIP = 13'h1000;
  localparam logic [12:0] QASR_CODE_RESET = 13'h0000;
  localparam logic [12:0] QASR_FD_MIN = 13'h1000;
  localparam logic [12:0] QASR_FD_MAX = 13'h0fff;
  localparam logic [12:0] QASR_PB_MIN = 13'h1800;
  localparam logic [12:0] QASR_PB_MAX = 13'h07ff;
  localparam logic [12:0] QASR_PU_MIN = 13'h0000;
  localparam logic [3:0] QASR_STEP_LAST = 4'h0;
  localparam logic [3:0] QASR_STEP_FIRST = 4'hc;
  localparam logic [1:0] QASR_MODE_CMOS = 2'h0;
  localparam logic [1:0] QASR_MODE_LVDS = 2'h1;
  localparam logic [1:0] QASR_MODE_LVDS_LP = 2'h2;
  typedef enum logic [1:0] {QASR_IDLE, QASR_RESOLVE, QASR_LOADED} qasr_sar_state_t;
endpackage : qasr_pkg

`timescale 1ns/10ps
`default_nettype none

module qasr_sar #(
  parameter int WIDTH = qasr_pkg::QASR_CODE_BITS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Held sample, two's complement
  input wire logic start,
  input wire logic [WIDTH-1:0] held_sample,
  // Result
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] code
);

  qasr_pkg::qasr_sar_state_t state;
  logic [3:0] step;
  logic [WIDTH-1:0] trial;
  logic [WIDTH-1:0] target;
  logic [WIDTH-1:0] bit_mask;
  logic [WIDTH-1:0] trial_keep;
  logic [WIDTH-1:0] next_trial;
  logic keep_bit;

  // Comparator works on offset binary so an unsigned compare is valid
  assign target = held_sample ^ qasr_pkg::QASR_SIGN_FLIP;
  assign bit_mask = WIDTH'(1) << step;
  assign trial_keep = trial | bit_mask;
  assign keep_bit = trial_keep <= target;
  assign next_trial = keep_bit ? trial_keep : trial;

  // One bit per clock, MSB weight first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= qasr_pkg::QASR_IDLE;
      step <= qasr_pkg::QASR_STEP_FIRST;
      trial <= qasr_pkg::QASR_CODE_RESET;
      code <= qasr_pkg::QASR_CODE_RESET;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        qasr_pkg::QASR_IDLE: begin
          if (start) begin
            state <= qasr_pkg::QASR_RESOLVE;
            step <= qasr_pkg::QASR_STEP_FIRST;
            trial <= qasr_pkg::QASR_CODE_RESET;
            busy <= 1'b1;
          end
        end
        qasr_pkg::QASR_RESOLVE: begin
          trial <= next_trial;
          if (step == qasr_pkg::QASR_STEP_LAST) begin
            state <= qasr_pkg::QASR_LOADED;
          end else begin
            step <= step - 4'h1;
          end
        end
        qasr_pkg::QASR_LOADED: begin
          // Back to two's complement; no clamping of any range
          code <= trial ^ qasr_pkg::QASR_SIGN_FLIP;
          done <= 1'b1;
          busy <= 1'b0;
          state <= qasr_pkg::QASR_IDLE;
        end
      endcase
    end
  end

endmodule : qasr_sar

`default_nettype wire

// File: verilog/qasr_top.sv
// Four-channel simultaneous-sampling converter control and LVDS serial readout
//
// What this block does
// - Mode select high or floating: four differential lanes plus differential echoed clock.
// - Channels one to four drive lanes A to D, each lane only its own.
// - Single rate: result MSB first, one bit per shift clock falling edge.
// - Double rate: one bit per shift clock edge, rising and falling, MSB first.
// - Echoed clock follows the shift clock with a small matched delay.
// - Strobe high is acquisition, low is conversion; host holds it high to sample.
// - Strobe falling edge samples all four channels together and starts readout.
// - Conversion resolves a 13-bit code by successive approximation, then loads it.
// - Frame data belongs to the previous conversion: one conversion of latency.
// - Code is 13-bit two's complement over twice the reference.
// - Fully differential codes run 1 0000 0000 0000 to 0 1111 1111 1111.
// - Pseudo-differential bipolar spans 2^12 codes, no configuration needed.
// - Floating mode select runs the differential outputs in low power.
// - Pseudo-differential unipolar gives non-negative codes, zero to positive maximum.

`timescale 1ns/10ps
`default_nettype none

module qasr_top #(
  parameter int CHANNELS = qasr_pkg::QASR_CHANNELS,
  parameter int WIDTH = qasr_pkg::QASR_CODE_BITS
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Conversion control pin, active low
  input wire logic convert_strobe_n,
  // Static straps
  input wire logic [1:0] output_mode_select,
  input wire logic rate_select,
  // Sampler front end, one two's complement level per channel
  input wire logic [CHANNELS*WIDTH-1:0] channel_level,
  // Host shift clock
  input wire logic shift_clk,
  // Serial lanes, differential
  output logic serial_lane_a_p,
  output logic serial_lane_a_n,
  output logic serial_lane_b_p,
  output logic serial_lane_b_n,
  output logic serial_lane_c_p,
  output logic serial_lane_c_n,
  output logic serial_lane_d_p,
  output logic serial_lane_d_n,
  // Echoed clock, differential
  output logic echoed_shift_clock_p,
  output logic echoed_shift_clock_n,
  // Output driver control and phase status
  output logic lvds_drive_en,
  output logic lvds_low_power,
  output logic acquiring,
  output logic converting
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, system domain

  logic cnv_meta;
  logic cnv_sync;
  logic cnv_prev;
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;
  logic rate_meta;
  logic rate_sync;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnv_meta <= 1'b1;
      cnv_sync <= 1'b1;
      cnv_prev <= 1'b1;
      mode_meta <= qasr_pkg::QASR_MODE_CMOS;
      mode_sync <= qasr_pkg::QASR_MODE_CMOS;
      rate_meta <= 1'b0;
      rate_sync <= 1'b0;
    end else begin
      cnv_meta <= convert_strobe_n;
      cnv_sync <= cnv_meta;
      cnv_prev <= cnv_sync;
      mode_meta <= output_mode_select;
      mode_sync <= mode_meta;
      rate_meta <= rate_select;
      rate_sync <= rate_meta;
    end
  end

  logic cnv_fall;
  logic any_busy;
  logic lvds_mode;
  logic lvds_lp_mode;

  assign cnv_fall = cnv_prev & ~cnv_sync;
  assign lvds_mode = (mode_sync == qasr_pkg::QASR_MODE_LVDS) || (mode_sync == qasr_pkg::QASR_MODE_LVDS_LP);
  assign lvds_lp_mode = mode_sync == qasr_pkg::QASR_MODE_LVDS_LP;

  ////////////////////////////////////////////////////////////////////////////
  // Phase and driver status

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acquiring <= 1'b0;
      converting <= 1'b0;
      lvds_drive_en <= 1'b0;
      lvds_low_power <= 1'b0;
    end else begin
      acquiring <= cnv_sync & ~any_busy;
      converting <= any_busy | cnv_fall;
      lvds_drive_en <= lvds_mode;
      lvds_low_power <= lvds_lp_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel sampling, conversion and frame word

  logic [CHANNELS-1:0] busy_vec;
  logic [CHANNELS*WIDTH-1:0] frame_word;
  logic [CHANNELS-1:0] lane_bit;

  assign any_busy = |busy_vec;

  // Count of edges since the frame began, cleared while the strobe is high
  logic [qasr_pkg::QASR_IDX_BITS-1:0] fall_idx;
  logic [qasr_pkg::QASR_IDX_BITS-1:0] rise_idx;
  logic rate_link;

  // Rate strap is static; the link side reads the settled system copy
  assign rate_link = rate_sync;

  always_ff @(negedge shift_clk or posedge convert_strobe_n) begin
    if (convert_strobe_n) begin
      fall_idx <= '0;
    end else if (fall_idx != qasr_pkg::QASR_IDX_BITS'(qasr_pkg::QASR_SDR_EDGES)) begin
      fall_idx <= fall_idx + qasr_pkg::QASR_IDX_BITS'(1);
    end
  end

  always_ff @(posedge shift_clk or posedge convert_strobe_n) begin
    if (convert_strobe_n) begin
      rise_idx <= '0;
    end else if (rise_idx != qasr_pkg::QASR_IDX_BITS'(qasr_pkg::QASR_DDR_EDGES)) begin
      rise_idx <= rise_idx + qasr_pkg::QASR_IDX_BITS'(1);
    end
  end

  // Bit positions, counted down from the MSB
  logic [qasr_pkg::QASR_IDX_BITS:0] fall_pos;
  logic [qasr_pkg::QASR_IDX_BITS:0] rise_pos;

  // Double rate: falling edges carry even positions, rising edges odd ones
  assign fall_pos = rate_link ? {fall_idx, 1'b0} : {1'b0, fall_idx};
  assign rise_pos = {rise_idx, 1'b1};

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] held;
      logic [WIDTH-1:0] result;
      logic [WIDTH-1:0] word;
      logic [WIDTH-1:0] code;
      logic done;
      logic fall_q;
      logic rise_q;
      logic fall_bit;
      logic rise_bit;

      assign level = channel_level[ch*WIDTH +: WIDTH];
      assign word = frame_word[ch*WIDTH +: WIDTH];

      // All four held on the same edge
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          held <= qasr_pkg::QASR_CODE_RESET;
          result <= qasr_pkg::QASR_CODE_RESET;
          frame_word[ch*WIDTH +: WIDTH] <= qasr_pkg::QASR_CODE_RESET;
        end else begin
          if (cnv_sync) begin
            held <= level;
          end
          if (done) begin
            result <= code;
          end
          if (cnv_fall) begin
            frame_word[ch*WIDTH +: WIDTH] <= result;
          end
        end
      end

      qasr_sar #(
        .WIDTH(WIDTH)
      ) u_sar (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(cnv_fall),
        .held_sample(held),
        .busy(busy_vec[ch]),
        .done(done),
        .code(code)
      );

      // Past the last bit the lane reads zero; trailing single-rate bits are padding
      assign fall_bit = (fall_pos < (qasr_pkg::QASR_IDX_BITS+1)'(WIDTH))
                        ? word[WIDTH-1-int'(fall_pos)] : 1'b0;
      assign rise_bit = (rise_pos < (qasr_pkg::QASR_IDX_BITS+1)'(WIDTH))
                        ? word[WIDTH-1-int'(rise_pos)] : 1'b0;

      // Frame word is frozen from strobe fall until the next one, so it is quasi-static here
      always_ff @(negedge shift_clk or posedge convert_strobe_n) begin
        if (convert_strobe_n) begin
          fall_q <= 1'b0;
        end else begin
          fall_q <= fall_bit;
        end
      end

      always_ff @(posedge shift_clk or posedge convert_strobe_n) begin
        if (convert_strobe_n) begin
          rise_q <= 1'b0;
        end else begin
          rise_q <= rise_bit;
        end
      end

      // While the clock is high in double rate, the rising-edge bit is on the lane
      assign lane_bit[ch] = (rate_link && shift_clk) ? rise_q : fall_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Differential outputs; held at a quiet level unless an LVDS mode is set

  always_comb begin
    serial_lane_a_p = lvds_drive_en & lane_bit[0];
    serial_lane_a_n = lvds_drive_en & ~lane_bit[0];
    serial_lane_b_p = lvds_drive_en & lane_bit[1];
    serial_lane_b_n = lvds_drive_en & ~lane_bit[1];
    serial_lane_c_p = lvds_drive_en & lane_bit[2];
    serial_lane_c_n = lvds_drive_en & ~lane_bit[2];
    serial_lane_d_p = lvds_drive_en & lane_bit[3];
    serial_lane_d_n = lvds_drive_en & ~lane_bit[3];
    // Echo passes through gates of the same depth as the lanes for skew match
    echoed_shift_clock_p = lvds_drive_en & shift_clk;
    echoed_shift_clock_n = lvds_drive_en & ~shift_clk;
  end

endmodule : qasr_top

`default_nettype wire

// File: test/qasr_host.sv
// Host model: drives the convert strobe and shift clock, captures the lanes
`timescale 1ns/10ps
`default_nettype none
module qasr_host (
  // Reference clock and strap
  input wire logic sys_clk,
  input wire logic rate_select,
  // Lanes from the device, d down to a
  input wire logic [3:0] lane,
  // Host outputs
  output logic convert_strobe_n,
  output logic shift_clk
);
  logic [12:0] cap [4];
  initial begin
    convert_strobe_n = 1'b1;
    shift_clk = 1'b1;
  end
  task automatic frame();
    int n;
    n = 0;
    foreach (cap[c]) cap[c] = 13'h0000;
    @(negedge sys_clk);
    convert_strobe_n = 1'b0;
    #48;
    // Clock idles high, so even edges fall
    for (int e = 0; e < (rate_select ? 16 : 32); e++) begin
      shift_clk = ~shift_clk;
      #8;
      if ((rate_select || e % 2 == 0) && n < 13) begin
        foreach (cap[c]) cap[c] = {cap[c][11:0], lane[c]};
        n++;
      end
      #8;
    end
    @(negedge sys_clk);
    convert_strobe_n = 1'b1;
    #100;
  endtask : frame
endmodule : qasr_host
`default_nettype wire

// File: test/qasr_props.sv
// Port-level assertions for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module qasr_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Inputs
  input wire logic convert_strobe_n,
  input wire logic [1:0] output_mode_select,
  input wire logic shift_clk,
  // Outputs
  input wire logic serial_lane_a_p,
  input wire logic serial_lane_a_n,
  input wire logic serial_lane_d_p,
  input wire logic echoed_shift_clock_p,
  input wire logic echoed_shift_clock_n,
  input wire logic lvds_drive_en,
  input wire logic lvds_low_power,
  input wire logic acquiring,
  input wire logic converting
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Strap passes two sync stages and one output register: wait three quiet edges
  logic settled;
  logic [1:0] settle_count;
  logic [1:0] mode_last;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      settle_count <= 2'h0;
      mode_last <= 2'h0;
    end else begin
      mode_last <= output_mode_select;
      if (output_mode_select != mode_last) begin
        settle_count <= 2'h0;
      end else if (settle_count != 2'h3) begin
        settle_count <= settle_count + 2'h1;
      end
    end
  end
  assign settled = (settle_count == 2'h3) && (output_mode_select == mode_last);
  a_echo_follow: assert property (lvds_drive_en |-> echoed_shift_clock_p == shift_clk)
    else $error("echo differs from shift clock");
  a_pair_compl: assert property (lvds_drive_en |-> echoed_shift_clock_n != echoed_shift_clock_p && serial_lane_a_n != serial_lane_a_p)
    else $error("pair not complementary");
  a_quiet_acq: assert property ($past(convert_strobe_n) && convert_strobe_n |-> !serial_lane_a_p && !serial_lane_d_p)
    else $error("lane active during acquisition");
  a_drive_mode: assert property (settled |-> lvds_drive_en == (output_mode_select inside {2'h1, 2'h2}))
    else $error("drive enable wrong for mode");
  a_low_power: assert property (settled |-> lvds_low_power == (output_mode_select == 2'h2))
    else $error("low power wrong for mode");
  a_conv_start: assert property ($fell(convert_strobe_n) && acquiring |-> ##[1:5] converting)
    else $error("conversion did not start");
  a_conv_length: assert property ($rose(converting) |-> converting [*8] ##[3:10] !converting)
    else $error("conversion length wrong");
  a_acq_excl: assert property (acquiring |-> !converting)
    else $error("acquiring while converting");
  a_acq_low: assert property (!convert_strobe_n [*5] |-> !acquiring)
    else $error("acquiring with strobe low");
  c_conv: cover property ($rose(converting));
  c_low_power: cover property (lvds_low_power && !convert_strobe_n);
  c_frame: cover property (lvds_drive_en && !convert_strobe_n && !shift_clk);
endmodule : qasr_props
bind qasr_top qasr_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .convert_strobe_n(convert_strobe_n),
  .output_mode_select(output_mode_select), .shift_clk(shift_clk), .serial_lane_a_p(serial_lane_a_p),
  .serial_lane_a_n(serial_lane_a_n), .serial_lane_d_p(serial_lane_d_p), .echoed_shift_clock_p(echoed_shift_clock_p),
  .echoed_shift_clock_n(echoed_shift_clock_n), .lvds_drive_en(lvds_drive_en), .lvds_low_power(lvds_low_power),
  .acquiring(acquiring), .converting(converting));
`default_nettype wire

// File: test/tb_quad_adc_serial_readout.sv
// Self-checking bench for the converter readout block
`timescale 1ns/10ps
`default_nettype none
module tb_quad_adc_serial_readout;
  logic sys_clk, rst_n, rate_select, shift_clk, strobe_n, lvds;
  logic [1:0] mode;
  logic [51:0] level;
  logic a_p, a_n, b_p, b_n, c_p, c_n, d_p, d_n, echo_p, echo_n, drive_en, low_power;
  logic [12:0] prev [4];
  logic [12:0] codes [6];
  int fail_count, tests_run, cycles;
  qasr_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .convert_strobe_n(strobe_n), .output_mode_select(mode),
    .rate_select(rate_select), .channel_level(level), .shift_clk(shift_clk), .serial_lane_a_p(a_p),
    .serial_lane_a_n(a_n), .serial_lane_b_p(b_p), .serial_lane_b_n(b_n), .serial_lane_c_p(c_p),
    .serial_lane_c_n(c_n), .serial_lane_d_p(d_p), .serial_lane_d_n(d_n), .echoed_shift_clock_p(echo_p),
    .echoed_shift_clock_n(echo_n), .lvds_drive_en(drive_en), .lvds_low_power(low_power), .acquiring(),
    .converting());
  qasr_host host (.sys_clk(sys_clk), .rate_select(rate_select), .lane({d_p, c_p, b_p, a_p}),
    .convert_strobe_n(strobe_n), .shift_clk(shift_clk));
  task automatic check(input string name, input logic [12:0] exp, input logic [12:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Whole run needs about 800 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    rate_select = 1'b0;
    mode = 2'h1;
    level = '0;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    foreach (prev[c]) prev[c] = 13'h0000;
    void'($urandom(32'h7584));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    // Every mode code with both rates; boundary codes rotate over channels
    for (int i = 0; i < 12; i++) begin
      codes = '{qasr_pkg::QASR_FD_MIN, qasr_pkg::QASR_FD_MAX, qasr_pkg::QASR_PB_MIN, qasr_pkg::QASR_PB_MAX,
        qasr_pkg::QASR_PU_MIN, 13'($urandom())};
      mode = 2'(i % 4);
      rate_select = i[2];
      lvds = mode inside {2'h1, 2'h2};
      for (int c = 0; c < 4; c++) level[c*13 +: 13] = codes[(i + c) % 6];
      repeat (4) @(negedge sys_clk);
      check("drive_en", {12'h000, lvds}, {12'h000, drive_en});
      check("low_power", {12'h000, mode == 2'h2}, {12'h000, low_power});
      host.frame();
      for (int c = 0; c < 4; c++) begin
        check("lane", lvds ? prev[c] : 13'h0000, host.cap[c]);
        prev[c] = level[c*13 +: 13];
      end
    end
    print_verdict();
  end
endmodule : tb_quad_adc_serial_readout
`default_nettype wire
